// file: verilog/host_bus16_fifo_port.sv
`timescale 1ns/100ps
// Notes on behaviour
// - FIFO submode active only when both mode fields equal 0x3.
// - Each transfer moves one 16-bit word over the data pins.
// - No address latch strobe and no address pins; data phase only.
// - Full and empty inputs are optional; disabled ones never pace transfers.
// - Data side of host-bus access, with pacing by the external flags.
// - A flag-held access stalls and blocks every other queued access.
module host_bus16_fifo_port
  import hb16_fifo_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  port_mode_sel,
  input  wire logic [3:0]  hb16_mode_sel,
  input  wire logic        full_flag_en,
  input  wire logic        empty_flag_en,
  input  wire logic        req_valid,
  input  wire xfer_req_s   req,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  output logic [15:0]      data_out,
  output logic             data_oe,
  input  wire logic [15:0] data_in,
  output logic             rd_n,
  output logic             wr_n,
  output logic             addr_latch_en,
  input  wire logic        ext_fifo_full_flag,
  input  wire logic        ext_fifo_empty_flag
);

  // ****************************************************************
  // Mode decode and flag pacing
  // ****************************************************************
  port_regs_s r_r;
  port_regs_s r_nxt;
  logic       fifo_mode_on;

  assign fifo_mode_on = (port_mode_sel == PORT_MODE_HOSTBUS16) && (hb16_mode_sel == HB16_MODE_FIFO);

  // A flag only counts when its enable is set.
  function automatic logic held_off(input logic write, input logic full_en, input logic full,
                                    input logic empty_en, input logic empty);
    held_off = write ? (full_en && full) : (empty_en && empty);
  endfunction

  logic pending_held;
  logic new_held;
  assign pending_held = held_off(r_r.write, full_flag_en, ext_fifo_full_flag,
                                 empty_flag_en, ext_fifo_empty_flag);
  assign new_held     = held_off(req.write, full_flag_en, ext_fifo_full_flag,
                                 empty_flag_en, ext_fifo_empty_flag);

  // Only one access is in flight, so a stalled one blocks all later ones.
  assign req_ready = fifo_mode_on && (r_r.st == ST_IDLE);

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  always_comb begin
    r_nxt           = r_r;
    r_nxt.rsp_valid = 1'b0;
    unique case (r_r.st)
      ST_IDLE: begin
        if (req_valid && req_ready) begin
          r_nxt.write = req.write;
          r_nxt.wdata = req.wdata;
          if (new_held) begin
            r_nxt.st = ST_WAIT;
          end else begin
            r_nxt.st      = ST_STROBE;
            r_nxt.cnt     = STROBE_LAST;
            r_nxt.data_oe = req.write;
            r_nxt.wr_n    = !req.write;
            r_nxt.rd_n    = req.write;
          end
        end
      end
      ST_WAIT: begin
        if (!pending_held) begin
          r_nxt.st      = ST_STROBE;
          r_nxt.cnt     = STROBE_LAST;
          r_nxt.data_oe = r_r.write;
          r_nxt.wr_n    = !r_r.write;
          r_nxt.rd_n    = r_r.write;
        end
      end
      ST_STROBE: begin
        if (r_r.cnt == CNT_ZERO) begin
          r_nxt.st        = ST_END;
          r_nxt.wr_n      = 1'b1;
          r_nxt.rd_n      = 1'b1;
          r_nxt.rsp_valid = 1'b1;
          if (!r_r.write) begin
            r_nxt.rdata = data_in;
          end
        end else begin
          r_nxt.cnt = r_r.cnt - 2'h1;
        end
      end
      ST_END: begin
        // Data is held one cycle past the rising strobe for hold time.
        r_nxt.data_oe = 1'b0;
        r_nxt.st      = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= REGS_RESET;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign rsp_valid     = r_r.rsp_valid;
  assign rsp_rdata     = r_r.rdata;
  assign data_out      = r_r.wdata;
  assign data_oe       = r_r.data_oe;
  assign rd_n          = r_r.rd_n;
  assign wr_n          = r_r.wr_n;
  assign addr_latch_en = 1'b0;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_ready_needs_mode;
    @(posedge ref_clk) disable iff (!rst_n)
      req_ready |-> (port_mode_sel == PORT_MODE_HOSTBUS16) && (hb16_mode_sel == HB16_MODE_FIFO);
  endproperty
  a_ready_needs_mode: assert property (p_ready_needs_mode) else $error("Ready outside FIFO mode.");

  property p_write_data_on_pins;
    @(posedge ref_clk) disable iff (!rst_n)
      (req_valid && req_ready && req.write) |=> (data_out == $past(req.wdata)) ##[0:200] (!wr_n && data_oe);
  endproperty
  a_write_data_on_pins: assert property (p_write_data_on_pins) else $error("Write word not driven.");

  property p_no_ale;
    @(posedge ref_clk) disable iff (!rst_n)
      !addr_latch_en;
  endproperty
  a_no_ale: assert property (p_no_ale) else $error("Address latch strobe driven.");

  property p_disabled_flags_ignored;
    @(posedge ref_clk) disable iff (!rst_n)
      (req_valid && req_ready && (req.write ? !full_flag_en : !empty_flag_en)) |=> (r_r.st == ST_STROBE);
  endproperty
  a_disabled_flags_ignored: assert property (p_disabled_flags_ignored) else $error("Disabled flag paced access.");

  sequence s_strobe_pulse;
    (!wr_n || !rd_n) [*2] ##1 (wr_n && rd_n && rsp_valid);
  endsequence
  property p_strobe_shape;
    @(posedge ref_clk) disable iff (!rst_n)
      ($fell(wr_n) || $fell(rd_n)) |-> s_strobe_pulse;
  endproperty
  a_strobe_shape: assert property (p_strobe_shape) else $error("Strobe length or response wrong.");

  property p_stall_blocks;
    @(posedge ref_clk) disable iff (!rst_n)
      (r_r.st == ST_WAIT) |-> !req_ready && wr_n && rd_n;
  endproperty
  a_stall_blocks: assert property (p_stall_blocks) else $error("Access not blocked during stall.");

  property p_full_holds_write;
    @(posedge ref_clk) disable iff (!rst_n)
      $fell(wr_n) |-> $past(!(full_flag_en && ext_fifo_full_flag));
  endproperty
  a_full_holds_write: assert property (p_full_holds_write) else $error("Write started while full.");

  property p_empty_holds_read;
    @(posedge ref_clk) disable iff (!rst_n)
      $fell(rd_n) |-> $past(!(empty_flag_en && ext_fifo_empty_flag));
  endproperty
  a_empty_holds_read: assert property (p_empty_holds_read) else $error("Read started while empty.");

  property p_strobes_exclusive;
    @(posedge ref_clk) disable iff (!rst_n)
      !(!wr_n && !rd_n);
  endproperty
  a_strobes_exclusive: assert property (p_strobes_exclusive) else $error("Both strobes low together.");

  property p_read_never_drives;
    @(posedge ref_clk) disable iff (!rst_n)
      !rd_n |-> !data_oe;
  endproperty
  a_read_never_drives: assert property (p_read_never_drives) else $error("Data pins driven during read.");

  property p_write_drives_pins;
    @(posedge ref_clk) disable iff (!rst_n)
      !wr_n |-> data_oe;
  endproperty
  a_write_drives_pins: assert property (p_write_drives_pins) else $error("Write strobe without driven data.");

  // The drive is kept one cycle past the strobe so the far side sees hold time.
  property p_oe_hold_one;
    @(posedge ref_clk) disable iff (!rst_n)
      ($rose(wr_n) && data_oe) |=> !data_oe;
  endproperty
  a_oe_hold_one: assert property (p_oe_hold_one) else $error("Data drive not released after hold.");

  property p_rsp_single;
    @(posedge ref_clk) disable iff (!rst_n)
      rsp_valid |=> !rsp_valid;
  endproperty
  a_rsp_single: assert property (p_rsp_single) else $error("Response longer than one cycle.");

  property p_strobe_gap;
    @(posedge ref_clk) disable iff (!rst_n)
      ($rose(wr_n) || $rose(rd_n)) |=> (wr_n && rd_n);
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("Strobes too close together.");

  property p_read_capture;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(rd_n) |-> (rsp_rdata == $past(data_in));
  endproperty
  a_read_capture: assert property (p_read_capture) else $error("Read word not captured.");

  property p_stall_release;
    @(posedge ref_clk) disable iff (!rst_n)
      ((r_r.st == ST_WAIT) && (r_r.write ? !(full_flag_en && ext_fifo_full_flag)
                                         : !(empty_flag_en && ext_fifo_empty_flag))) |=> (!wr_n || !rd_n);
  endproperty
  a_stall_release: assert property (p_stall_release) else $error("Stalled access not released.");

endmodule

// file: verilog/hb16_fifo_pkg.sv
package hb16_fifo_pkg;

  // ****************************************************************
  // Mode selection
  // ****************************************************************
  localparam logic [3:0] PORT_MODE_HOSTBUS16 = 4'h3;
  localparam logic [3:0] HB16_MODE_FIFO      = 4'h3;

  // ****************************************************************
  // Data path and timing
  // ****************************************************************
  localparam int          DATA_W        = 16;
  localparam int          STROBE_NS     = 20;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          STROBE_CYC_I  = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  STROBE_LAST   = 2'(STROBE_CYC_I - 1);
  localparam logic [1:0]  CNT_ZERO      = 2'h0;
  localparam logic [15:0] DATA_ZERO     = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_WAIT   = 2'b01,
    ST_STROBE = 2'b10,
    ST_END    = 2'b11
  } port_state_e;

  typedef struct packed {
    logic        write;
    logic [15:0] wdata;
  } xfer_req_s;

  typedef struct packed {
    port_state_e st;
    logic        write;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [1:0]  cnt;
    logic        rsp_valid;
    logic        data_oe;
    logic        rd_n;
    logic        wr_n;
  } port_regs_s;

  localparam port_regs_s REGS_RESET = '{
    st:        ST_IDLE,
    write:     1'b0,
    wdata:     DATA_ZERO,
    rdata:     DATA_ZERO,
    cnt:       CNT_ZERO,
    rsp_valid: 1'b0,
    data_oe:   1'b0,
    rd_n:      1'b1,
    wr_n:      1'b1
  };

endpackage

// file: dv/ext_fifo_model.sv
`timescale 1ns/100ps
// ************************************************
// External FIFO with far-side fill and drain hooks
// ************************************************
module ext_fifo_model
  import hb16_fifo_pkg::*;
#(parameter int DEPTH = 2)
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  input  wire logic        fill,
  input  wire logic        drain,
  output logic [15:0]      data_in,
  output logic             ext_fifo_full_flag,
  output logic             ext_fifo_empty_flag
);
  logic [15:0] mem [DEPTH];
  logic [15:0] wlat;
  logic [15:0] last;
  logic        wr_q;
  logic        rd_q;
  int          cnt;
  assign ext_fifo_full_flag  = (cnt == DEPTH);
  assign ext_fifo_empty_flag = (cnt == 0);
  // Released pins show the inverse of the last word, so a stale value never reads as good.
  assign data_in = rd_n ? ~last : mem[0];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      wr_q <= 1'b1;
      rd_q <= 1'b1;
      last <= 16'h0000;
    end else begin
      wr_q <= wr_n;
      rd_q <= rd_n;
      if (!wr_n && data_oe)
        wlat <= data_out;
      if (!rd_n)
        last <= mem[0];
      if ((fill || (wr_n && !wr_q)) && !ext_fifo_full_flag) begin
        mem[cnt] <= fill ? 16'hA5C3 : wlat;
        cnt <= cnt + 1;
      end else if ((drain || (rd_n && !rd_q)) && !ext_fifo_empty_flag) begin
        for (int i = 0; i < DEPTH - 1; i++)
          mem[i] <= mem[i + 1];
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// file: dv/tb_top.sv
`timescale 1ns/100ps
module tb_top import hb16_fifo_pkg::*; ;
  logic        ref_clk, rst_n, full_flag_en, empty_flag_en, req_valid, req_ready, rsp_valid;
  logic        data_oe, rd_n, wr_n, addr_latch_en, ext_fifo_full_flag, ext_fifo_empty_flag, fill, drain;
  logic [3:0]  port_mode_sel, hb16_mode_sel;
  logic [15:0] rsp_rdata, data_out, data_in;
  xfer_req_s   req;
  int          bad_count, n_checks, cyc, lat;
  host_bus16_fifo_port DUT (.ref_clk, .rst_n, .port_mode_sel, .hb16_mode_sel, .full_flag_en,
    .empty_flag_en, .req_valid, .req, .req_ready, .rsp_valid, .rsp_rdata, .data_out, .data_oe,
    .data_in, .rd_n, .wr_n, .addr_latch_en, .ext_fifo_full_flag, .ext_fifo_empty_flag);
  ext_fifo_model far (.ref_clk, .rst_n, .rd_n, .wr_n, .data_out, .data_oe, .fill, .drain, .data_in,
    .ext_fifo_full_flag, .ext_fifo_empty_flag);
  // ****************
  // Shared tasks
  // ****************
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Entered at a rising edge; lat counts cycles from the taking edge to the response.
  task automatic access(input logic w, input logic [15:0] d, input int lim);
    req_valid <= 1'b1;
    req <= '{write: w, wdata: d};
    do @(negedge ref_clk); while (req_ready !== 1'b1);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge ref_clk);
      lat++;
    end while (rsp_valid !== 1'b1 && lat < lim);
    @(posedge ref_clk);
  endtask
  // Holds the far side off for six cycles, checking once, at the sixth falling edge, that the port is blocked.
  task automatic release_after(input logic use_fill);
    repeat (6) @(negedge ref_clk);
    cmp(16'(req_ready), 16'h0000);
    @(posedge ref_clk);
    if (use_fill)
      fill <= 1'b1;
    else
      drain <= 1'b1;
    @(posedge ref_clk);
    fill <= 1'b0;
    drain <= 1'b0;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic mode_check();
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      port_mode_sel <= 4'(i);
      @(negedge ref_clk);
      cmp(16'(req_ready), 16'(i == 3));
      @(posedge ref_clk);
      port_mode_sel <= 4'h3;
      hb16_mode_sel <= 4'(i);
      @(negedge ref_clk);
      cmp(16'(req_ready), 16'(i == 3));
      cmp(16'(addr_latch_en), 16'h0000);
      @(posedge ref_clk);
      hb16_mode_sel <= 4'h3;
    end
    @(posedge ref_clk);
  endtask
  task automatic write_read();
    access(1'b1, 16'h1234, 10);
    cmp(16'(lat), 16'h0003);
    access(1'b0, 16'h0000, 10);
    cmp(rsp_rdata, 16'h1234);
  endtask
  task automatic full_stall();
    access(1'b1, 16'hBEEF, 10);
    access(1'b1, 16'h0F0F, 10);
    fork
      release_after(1'b0);
    join_none
    access(1'b1, 16'h7E81, 30);
    cmp(16'(lat > 7 && lat < 30), 16'h0001);
    access(1'b0, 16'h0000, 10);
    cmp(rsp_rdata, 16'h0F0F);
    access(1'b0, 16'h0000, 10);
    cmp(rsp_rdata, 16'h7E81);
  endtask
  task automatic empty_stall();
    fork
      release_after(1'b1);
    join_none
    access(1'b0, 16'h0000, 30);
    cmp(16'(lat > 7 && lat < 30), 16'h0001);
    cmp(rsp_rdata, 16'hA5C3);
    empty_flag_en <= 1'b0;
    full_flag_en  <= 1'b0;
    access(1'b0, 16'h0000, 10);
    cmp(16'(lat), 16'h0003);
    // Two writes fill the far side; the third must still go straight through.
    access(1'b1, 16'h0001, 10);
    access(1'b1, 16'h0002, 10);
    access(1'b1, 16'h0003, 10);
    cmp(16'(lat), 16'h0003);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    {rst_n, req_valid, fill, drain, req} = '0;
    {full_flag_en, empty_flag_en, port_mode_sel, hb16_mode_sel} = {2'h3, 4'h3, 4'h3};
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    mode_check();
    write_read();
    full_stall();
    empty_stall();
    end_sim();
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_sim();
    end
  end
endmodule
